// ==== src/dpsa_host.sv ====
// Host-port controller that drives one side of the dual-port semaphore flags
// ----------------------------------------------------------------
// How it works
// - Startup writes one into all eight flags
// - Acquire writes zero, then reads it back
// - Release writes one to the owned flag
// - Failed request is withdrawn by writing one
// ----------------------------------------------------------------
`timescale 1ns/100ps

module dpsa_host (
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  input  wire dpsa_pkg::dpsa_cmd_t          cmd,
  output logic                              cmd_ready,
  output dpsa_pkg::dpsa_rsp_t               rsp,
  output logic                              flag_space_select_n,
  output logic                              write_n,
  output logic                              read_en_n,
  output logic [dpsa_pkg::IDX_W-1:0]        flag_index,
  output logic [dpsa_pkg::DATA_W-1:0]       data_out,
  output logic                              data_oe,
  input  wire logic [dpsa_pkg::DATA_W-1:0]  data_in
);

  // ----------------------------------------------------------------
  // Bus cycle helpers
  // ----------------------------------------------------------------
  function automatic dpsa_pkg::dpsa_pins_t write_pins(
    input logic [dpsa_pkg::IDX_W-1:0] idx,
    input logic                       bit_val
  );
    dpsa_pkg::dpsa_pins_t p;
    p                     = dpsa_pkg::PINS_IDLE;
    p.flag_space_select_n = 1'b0;
    p.write_n             = 1'b0;
    p.flag_index          = idx;
    p.data_out            = {dpsa_pkg::DATA_W{bit_val}};
    p.data_oe             = 1'b1;
    return p;
  endfunction : write_pins

  function automatic dpsa_pkg::dpsa_pins_t read_pins(
    input logic [dpsa_pkg::IDX_W-1:0] idx
  );
    dpsa_pkg::dpsa_pins_t p;
    p                     = dpsa_pkg::PINS_IDLE;
    p.flag_space_select_n = 1'b0;
    p.read_en_n           = 1'b0;
    p.flag_index          = idx;
    return p;
  endfunction : read_pins

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dpsa_pkg::dpsa_regs_t s_r;
  dpsa_pkg::dpsa_regs_t s_nxt;

  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.rsp.done = 1'b0;
    unique case (s_r.state)
      dpsa_pkg::ST_IDLE:
      begin
        if (s_r.ready && cmd.valid && cmd.op != dpsa_pkg::OP_NONE)
        begin
          s_nxt.ready = 1'b0;
          s_nxt.op    = cmd.op;
          s_nxt.state = dpsa_pkg::ST_WRITE;
          s_nxt.cnt   = dpsa_pkg::ACCESS_CYC;
          if (cmd.op == dpsa_pkg::OP_INIT)
          begin
            // Flags power up unknown; free every one from this side
            s_nxt.idx   = dpsa_pkg::IDX_FIRST;
            s_nxt.wbit  = dpsa_pkg::FLAG_FREE;
            s_nxt.phase = dpsa_pkg::PH_FREE;
          end
          else if (cmd.op == dpsa_pkg::OP_ACQUIRE)
          begin
            s_nxt.idx   = cmd.index;
            s_nxt.wbit  = dpsa_pkg::FLAG_TAKE;
            s_nxt.phase = dpsa_pkg::PH_REQUEST;
          end
          else
          begin
            s_nxt.idx   = cmd.index;
            s_nxt.wbit  = dpsa_pkg::FLAG_FREE;
            s_nxt.phase = dpsa_pkg::PH_FREE;
          end
          s_nxt.pins = write_pins(s_nxt.idx, s_nxt.wbit);
        end
      end
      dpsa_pkg::ST_WRITE:
      begin
        if (s_r.cnt == dpsa_pkg::CNT_ONE)
        begin
          s_nxt.pins  = dpsa_pkg::PINS_IDLE;
          s_nxt.state = dpsa_pkg::ST_GAP;
          s_nxt.cnt   = dpsa_pkg::GAP_CYC;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - dpsa_pkg::CNT_ONE;
        end
      end
      dpsa_pkg::ST_READ:
      begin
        if (s_r.cnt == dpsa_pkg::CNT_ONE)
        begin
          // Owner sees zero, loser sees one
          s_nxt.seen  = data_in[dpsa_pkg::REQ_BIT];
          // Drop select so the device latch refreshes next time
          s_nxt.pins  = dpsa_pkg::PINS_IDLE;
          s_nxt.state = dpsa_pkg::ST_GAP;
          s_nxt.cnt   = dpsa_pkg::GAP_CYC;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - dpsa_pkg::CNT_ONE;
        end
      end
      dpsa_pkg::ST_GAP:
      begin
        if (s_r.cnt > dpsa_pkg::CNT_ONE)
        begin
          s_nxt.cnt = s_r.cnt - dpsa_pkg::CNT_ONE;
        end
        else
        begin
          s_nxt.state = dpsa_pkg::ST_IDLE;
          s_nxt.cnt   = dpsa_pkg::CNT_ZERO;
          unique case (s_r.phase)
            dpsa_pkg::PH_REQUEST:
            begin
              // Read back only after the request write
              s_nxt.phase = dpsa_pkg::PH_CHECK;
              s_nxt.state = dpsa_pkg::ST_READ;
              s_nxt.cnt   = dpsa_pkg::ACCESS_CYC;
              s_nxt.pins  = read_pins(s_r.idx);
            end
            dpsa_pkg::PH_CHECK:
            begin
              if (s_r.seen == dpsa_pkg::FLAG_TAKE)
              begin
                s_nxt.rsp = '{done: 1'b1, granted: 1'b1, index: s_r.idx};
                s_nxt.ready = 1'b1;
              end
              else
              begin
                // A left-over request would hand us the flag unasked
                s_nxt.phase = dpsa_pkg::PH_WITHDRAW;
                s_nxt.wbit  = dpsa_pkg::FLAG_FREE;
                s_nxt.state = dpsa_pkg::ST_WRITE;
                s_nxt.cnt   = dpsa_pkg::ACCESS_CYC;
                s_nxt.pins  = write_pins(s_r.idx, dpsa_pkg::FLAG_FREE);
              end
            end
            dpsa_pkg::PH_WITHDRAW:
            begin
              s_nxt.rsp   = '{done: 1'b1, granted: 1'b0, index: s_r.idx};
              s_nxt.ready = 1'b1;
            end
            dpsa_pkg::PH_FREE:
            begin
              if (s_r.op == dpsa_pkg::OP_INIT && s_r.idx != dpsa_pkg::IDX_LAST)
              begin
                s_nxt.idx   = s_r.idx + dpsa_pkg::IDX_STEP;
                s_nxt.state = dpsa_pkg::ST_WRITE;
                s_nxt.cnt   = dpsa_pkg::ACCESS_CYC;
                s_nxt.pins  = write_pins(s_nxt.idx, dpsa_pkg::FLAG_FREE);
              end
              else
              begin
                s_nxt.rsp   = '{done: 1'b1, granted: 1'b0, index: s_r.idx};
                s_nxt.ready = 1'b1;
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s_r.state <= dpsa_pkg::ST_IDLE;
      s_r.phase <= dpsa_pkg::PH_FREE;
      s_r.op    <= dpsa_pkg::OP_NONE;
      s_r.cnt   <= dpsa_pkg::CNT_ZERO;
      s_r.idx   <= dpsa_pkg::IDX_FIRST;
      s_r.wbit  <= dpsa_pkg::FLAG_FREE;
      s_r.seen  <= dpsa_pkg::FLAG_FREE;
      s_r.ready <= 1'b1;
      s_r.rsp   <= '0;
      s_r.pins  <= dpsa_pkg::PINS_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmd_ready           = s_r.ready;
  assign rsp                 = s_r.rsp;
  assign flag_space_select_n = s_r.pins.flag_space_select_n;
  assign write_n             = s_r.pins.write_n;
  assign read_en_n           = s_r.pins.read_en_n;
  assign flag_index          = s_r.pins.flag_index;
  assign data_out            = s_r.pins.data_out;
  assign data_oe             = s_r.pins.data_oe;

endmodule : dpsa_host

// ==== inc/dpsa_pkg.sv ====
// Constants, states and carrier structs of the semaphore host-port controller
package dpsa_pkg;

  // ----------------------------------------------------------------
  // Pin widths and flag space
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned IDX_W     = 3;
  localparam logic [2:0]  IDX_FIRST = 3'h0;
  localparam logic [2:0]  IDX_LAST  = 3'h7;
  localparam logic [2:0]  IDX_STEP  = 3'h1;
  localparam int unsigned REQ_BIT   = 0;
  localparam logic        FLAG_TAKE = 1'b0;
  localparam logic        FLAG_FREE = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned ACCESS_NS     = 200;
  localparam int unsigned GAP_NS        = 100;
  localparam int unsigned CNT_W         = 4;
  localparam logic [3:0]  ACCESS_CYC    =
    4'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  GAP_CYC       =
    4'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  CNT_ONE       = 4'h1;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;

  // ----------------------------------------------------------------
  // Commands, states and phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_INIT    = 2'h0,
    OP_ACQUIRE = 2'h1,
    OP_RELEASE = 2'h2,
    OP_NONE    = 2'h3
  } dpsa_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ,
    ST_GAP
  } dpsa_state_t;

  typedef enum logic [1:0] {
    PH_REQUEST,
    PH_CHECK,
    PH_WITHDRAW,
    PH_FREE
  } dpsa_phase_t;

  // ----------------------------------------------------------------
  // Carrier structs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    dpsa_op_t          op;
    logic [IDX_W-1:0]  index;
  } dpsa_cmd_t;

  typedef struct packed {
    logic              done;
    logic              granted;
    logic [IDX_W-1:0]  index;
  } dpsa_rsp_t;

  typedef struct packed {
    logic              flag_space_select_n;
    logic              write_n;
    logic              read_en_n;
    logic [IDX_W-1:0]  flag_index;
    logic [DATA_W-1:0] data_out;
    logic              data_oe;
  } dpsa_pins_t;

  localparam dpsa_pins_t PINS_IDLE = '{
    flag_space_select_n: 1'b1,
    write_n:             1'b1,
    read_en_n:           1'b1,
    flag_index:          3'h0,
    data_out:            8'hff,
    data_oe:             1'b0
  };

  typedef struct packed {
    dpsa_state_t       state;
    dpsa_phase_t       phase;
    dpsa_op_t          op;
    logic [CNT_W-1:0]  cnt;
    logic [IDX_W-1:0]  idx;
    logic              wbit;
    logic              seen;
    logic              ready;
    dpsa_rsp_t         rsp;
    dpsa_pins_t        pins;
  } dpsa_regs_t;

endpackage : dpsa_pkg

// ==== verification/dpsa_host_asserts.sv ====
// Concurrent checks on the host-port pins of the semaphore controller
`timescale 1ns/100ps

module dpsa_host_asserts (
  input wire logic                        ref_clk,
  input wire logic                        sys_rst,
  input wire dpsa_pkg::dpsa_cmd_t         cmd,
  input wire logic                        cmd_ready,
  input wire dpsa_pkg::dpsa_rsp_t         rsp,
  input wire logic                        flag_space_select_n,
  input wire logic                        write_n,
  input wire logic                        read_en_n,
  input wire logic [dpsa_pkg::IDX_W-1:0]  flag_index,
  input wire logic [dpsa_pkg::DATA_W-1:0] data_out,
  input wire logic                        data_oe,
  input wire logic [dpsa_pkg::DATA_W-1:0] data_in
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Access shape
  // ----------------------------------------------------------------
  a_strobe_apart: assert property (write_n || read_en_n)
    else $error("write and read strobes low together");
  a_oe_with_write: assert property (data_oe == !write_n)
    else $error("data enable differs from write strobe");
  a_select_held: assert property ((!write_n || !read_en_n) |-> !flag_space_select_n)
    else $error("strobe low without flag space select");
  a_read_release: assert property ($rose(read_en_n) |-> flag_space_select_n)
    else $error("select stays low after read");

  // ----------------------------------------------------------------
  // Sequences of a command
  // ----------------------------------------------------------------
  a_acq_readback: assert property (($fell(write_n) && data_out == 8'h00) |->
    ##3 (!read_en_n && !flag_space_select_n && flag_index == $past(flag_index, 3)))
    else $error("zero write not followed by read back");
  a_won_grant: assert property ((!read_en_n && !$past(read_en_n) && !data_in[0])
    |-> ##2 (rsp.done && rsp.granted))
    else $error("zero read back not granted");
  a_lost_withdraw: assert property ((!read_en_n && !$past(read_en_n) && data_in[0])
    |-> ##2 (!write_n && data_out == 8'hff) ##3 (rsp.done && !rsp.granted))
    else $error("lost request not withdrawn");
  a_release_one: assert property ((cmd_ready && cmd.valid &&
    cmd.op == dpsa_pkg::OP_RELEASE) |=> (!write_n && data_out == 8'hff &&
    flag_index == $past(cmd.index)) ##3 (rsp.done && !rsp.granted))
    else $error("release does not write one");
  a_init_all: assert property ((cmd_ready && cmd.valid && cmd.op == dpsa_pkg::OP_INIT)
    |=> (!write_n && data_out == 8'hff && flag_index == 3'h0) ##24 (rsp.done && rsp.index == 3'h7))
    else $error("init does not free eight flags");
endmodule : dpsa_host_asserts

bind dpsa_host dpsa_host_asserts u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd(cmd),
  .cmd_ready(cmd_ready), .rsp(rsp), .flag_space_select_n(flag_space_select_n),
  .write_n(write_n), .read_en_n(read_en_n), .flag_index(flag_index),
  .data_out(data_out), .data_oe(data_oe), .data_in(data_in));

// ==== verification/dpsa_sem_model.sv ====
// Behavioural eight-flag semaphore device; left port faces the controller
`timescale 1ns/100ps

module dpsa_sem_model (
  input wire logic        ref_clk,
  input wire logic        flag_space_select_n,
  input wire logic        write_n,
  input wire logic        read_en_n,
  input wire logic [2:0]  flag_index,
  input wire logic [7:0]  data_out,
  output logic [7:0]      data_in,
  input wire logic        oth_sel_n,
  input wire logic        oth_we_n,
  input wire logic [2:0]  oth_idx,
  input wire logic        oth_bit
);
  // No power-up clearing: left side starts owning every flag
  logic [7:0] req_l = 8'h00;
  logic [7:0] req_r = 8'hff;
  logic [7:0] own_l = 8'hff;
  logic [7:0] own_r = 8'h00;
  logic       rd_act = 1'b0;
  logic       rd_val = 1'b1;

  always @(posedge ref_clk)
  begin
    if (!flag_space_select_n && !write_n) req_l[flag_index] = data_out[0];
    if (!oth_sel_n && !oth_we_n) req_r[oth_idx] = oth_bit;
    for (int i = 0; i < 8; i++)
    begin
      if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
      if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
      // Left is looked at first, so a same-edge tie goes left
      if (!own_l[i] && !own_r[i])
      begin
        if (!req_l[i]) own_l[i] = 1'b1;
        else if (!req_r[i]) own_r[i] = 1'b1;
      end
    end
    if (!flag_space_select_n && !read_en_n)
    begin
      if (!rd_act) rd_val = ~own_l[flag_index];
      rd_act = 1'b1;
    end
    else rd_act = 1'b0;
  end

  // Deselected bus shows the inverse of the last read
  assign data_in = rd_act ? {8{rd_val}} : {8{~rd_val}};
endmodule : dpsa_sem_model

// ==== verification/test_dpsa_host.sv ====
// Self-checking bench for the semaphore host-port controller
`timescale 1ns/100ps

module test_dpsa_host;
  logic                ref_clk = 1'b0;
  logic                sys_rst = 1'b1;
  dpsa_pkg::dpsa_cmd_t cmd = '0;
  dpsa_pkg::dpsa_rsp_t rsp;
  logic                cmd_ready, sel_n, we_n, oe_n, d_oe;
  logic [2:0]          fidx, k, oth_idx = 3'h0;
  logic [7:0]          dout, din, rown = 8'h00;
  logic                oth_sel_n = 1'b1, oth_we_n = 1'b1, oth_bit = 1'b1;
  int                  failures = 0, comparisons = 0, cycles = 0;

  dpsa_host u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd(cmd), .cmd_ready(cmd_ready),
    .rsp(rsp), .flag_space_select_n(sel_n), .write_n(we_n), .read_en_n(oe_n),
    .flag_index(fidx), .data_out(dout), .data_oe(d_oe), .data_in(din));
  dpsa_sem_model u_dev (.ref_clk(ref_clk), .flag_space_select_n(sel_n), .write_n(we_n),
    .read_en_n(oe_n), .flag_index(fidx), .data_out(dout), .data_in(din),
    .oth_sel_n(oth_sel_n), .oth_we_n(oth_we_n), .oth_idx(oth_idx), .oth_bit(oth_bit));

  always #50 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  // Run is well under a thousand cycles; the ceiling leaves ample margin
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      failures++;
      test_done();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic [7:0] exp_grant(input logic [7:0] r, input logic [2:0] i);
    return {7'h0, ~r[i]};
  endfunction : exp_grant

  task automatic host(input dpsa_pkg::dpsa_op_t op, input logic [2:0] idx);
    int n;
    n = 0;
    @(negedge ref_clk);
    cmd = '{valid: 1'b1, op: op, index: idx};
    @(negedge ref_clk);
    cmd.valid = 1'b0;
    check({7'h0, cmd_ready}, 8'h00);
    while (rsp.done !== 1'b1 && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    check({7'h0, rsp.done}, 8'h01);
    check({7'h0, cmd_ready}, 8'h01);
    check({5'h0, rsp.index}, {5'h0, (op == dpsa_pkg::OP_INIT) ? 3'h7 : idx});
  endtask : host

  // Far-side processor writes one flag for one edge
  task automatic oth(input logic [2:0] idx, input logic b);
    @(negedge ref_clk);
    {oth_sel_n, oth_we_n, oth_idx, oth_bit} = {2'b00, idx, b};
    @(negedge ref_clk);
    {oth_sel_n, oth_we_n, oth_bit} = {2'b11, ~b};
  endtask : oth

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h413c));
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    check({4'h0, sel_n, we_n, oe_n, d_oe}, 8'h0e);
    host(dpsa_pkg::OP_INIT, 3'h5);
    check({5'h0, rsp.index}, 8'h07);
    check(u_dev.req_l, 8'hff);
    check(u_dev.own_l, 8'h00);
    for (int i = 0; i < 8; i++) oth(3'(i), 1'b1);
    $display("test init done");
    k = 3'($urandom);
    host(dpsa_pkg::OP_ACQUIRE, k);
    check({7'h0, rsp.granted}, 8'h01);
    oth(k, 1'b0);
    check({7'h0, u_dev.own_r[k]}, 8'h00);
    host(dpsa_pkg::OP_RELEASE, k);
    check({7'h0, u_dev.own_r[k]}, 8'h01);
    host(dpsa_pkg::OP_ACQUIRE, k);
    check({7'h0, rsp.granted}, 8'h00);
    check({7'h0, u_dev.req_l[k]}, 8'h01);
    oth(k, 1'b1);
    $display("test handover done");
    // Idle op must start no access
    @(negedge ref_clk);
    cmd = '{valid: 1'b1, op: dpsa_pkg::OP_NONE, index: 3'h2};
    @(negedge ref_clk);
    cmd.valid = 1'b0;
    check({6'h0, cmd_ready, sel_n}, 8'h03);
    // Far side requests on the same edge as our write: a tie
    k = 3'($urandom);
    fork
      host(dpsa_pkg::OP_ACQUIRE, k);
      begin
        @(negedge ref_clk);
        oth(k, 1'b0);
      end
    join
    check({7'h0, rsp.granted}, 8'h01);
    check({7'h0, u_dev.own_r[k]}, 8'h00);
    host(dpsa_pkg::OP_RELEASE, k);
    check({7'h0, u_dev.own_r[k]}, 8'h01);
    oth(k, 1'b1);
    check(u_dev.own_l | u_dev.own_r, 8'h00);
    $display("test corner done");
    for (int i = 0; i < 8; i++) host(dpsa_pkg::OP_ACQUIRE, 3'(i));
    check(u_dev.own_l, 8'hff);
    for (int i = 7; i >= 0; i--) host(dpsa_pkg::OP_RELEASE, 3'(i));
    check(u_dev.own_l | u_dev.own_r, 8'h00);
    $display("test all flags done");
    repeat (24)
    begin
      k = 3'($urandom);
      if ($urandom % 2 == 1)
      begin
        oth(k, 1'b0);
        rown[k] = 1'b1;
      end
      host(dpsa_pkg::OP_ACQUIRE, k);
      check({7'h0, rsp.granted}, exp_grant(rown, k));
      if (rown[k] === 1'b0) host(dpsa_pkg::OP_RELEASE, k);
      else oth(k, 1'b1);
      rown[k] = 1'b0;
    end
    check(u_dev.req_l, 8'hff);
    $display("test random done");
    test_done();
  end
endmodule : test_dpsa_host
